// [tgd_fifo.sv]
/*
 * tgd_fifo: synchronous FIFO with valid/ready on both sides.
 * assumes one clock, synchronous active-high reset, power-of-two depth.
 */
`timescale 1ns/1ps
`default_nettype none
module tgd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : gBadParam
        $error("DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] memArr [DEPTH];
    logic [AW:0] wrPtr_ff;
    logic [AW:0] rdPtr_ff;
    logic full;
    logic empty;
    logic doPush;
    logic doPop;

    assign full = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    assign empty = (wrPtr_ff == rdPtr_ff);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = memArr[rdPtr_ff[AW-1:0]];
    assign doPush = inValid && !full;
    assign doPop = outReady && !empty;

    // storage has no reset; only the pointers carry state
    always_ff @(posedge clk) begin
        if (doPush) begin
            memArr[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_ff <= '0;
        end else if (doPush) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdPtr_ff <= '0;
        end else if (doPop) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end
endmodule : tgd_fifo
`default_nettype wire

// [tgd_peer.sv]
/* tgd_peer: far-side switch taking egress results and owning the link state.
   assumes the bench drives stall, cut and the peer's trunk setup flag. */
`timescale 1ns/1ps
`default_nettype none
module tgd_peer (
    input wire logic stall,
    input wire logic peerCfg,
    input wire logic [3:0] cut,
    output logic egrReady,
    output logic [3:0] linkUp
);
    // stall models a slow peer
    assign egrReady = !stall;
    // links stay down until the peer has its matching trunk set up
    assign linkUp = peerCfg ? ~cut : 4'h0;
endmodule : tgd_peer
`default_nettype wire

// [tgd_props.sv]
/* tgd_props: port-level checks on the trunk group distributor.
   assumes a bind onto trunk_group_distributor, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module tgd_props #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frmReady,
    input wire logic egrValid,
    input wire logic egrReady,
    input wire logic [1:0] egrPort,
    input wire logic egrDrop,
    input wire logic [47:0] portVlan,
    input wire logic [3:0] portForward
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_b_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write response late");
    property p_r_after;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_after: assert property (p_r_after) else $error("read data late");
    property p_no_second;
        (s_axi_bvalid |-> !s_axi_awready) and (s_axi_rvalid |-> !s_axi_arready);
    endproperty
    a_no_second: assert property (p_no_second) else $error("second request taken early");
    property p_egr_hold;
        egrValid && !egrReady |=> egrValid && $stable(egrPort) && $stable(egrDrop);
    endproperty
    a_egr_hold: assert property (p_egr_hold) else $error("egress changed while stalled");
    property p_rst_val;
        disable iff (1'b0) sys_rst |=> !egrValid && portForward == 4'h0 && portVlan == 48'h0;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset outputs wrong");
    property p_rdy_rel;
        $fell(sys_rst) |-> frmReady;
    endproperty
    a_rdy_rel: assert property (p_rdy_rel) else $error("frame input refused");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_drop: cover property (egrValid && egrReady && egrDrop);
    c_full: cover property (!sys_rst && !frmReady);
endmodule : tgd_props
bind trunk_group_distributor tgd_props #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frmReady, .egrValid, .egrReady, .egrPort,
    .egrDrop, .portVlan, .portForward);
`default_nettype wire

// [trunk_group_distributor.sv]
/*
 * tgd_pkg and trunk_group_distributor: trunk group configuration, validation and
 * per-frame egress member choice for four external ports, with an AXI4-Lite slave.
 * assumes link, speed, duplex and spanning tree inputs synchronous to clk, and
 * frame descriptors resolved to a logical destination port.
 */
`default_nettype none
package tgd_pkg;
    localparam int NPORT = 4;
    localparam int NGROUP = 2;
    localparam logic [7:0] OFS_DIST = 8'h00;
    localparam logic [7:0] OFS_GRP0 = 8'h04;
    localparam logic [7:0] OFS_GRP1 = 8'h08;
    localparam logic [7:0] OFS_KEY = 8'h0c;
    localparam logic [7:0] OFS_VLAN01 = 8'h10;
    localparam logic [7:0] OFS_VLAN23 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam int GRP_MEM_LSB = 0;
    localparam int GRP_EN_BIT = 4;
    localparam int GRP_DYN_BIT = 5;
    localparam int GRP_NUM_LSB = 8;
    localparam int DIST_NONIP_LSB = 0;
    localparam int DIST_IP_LSB = 2;
    localparam int VLAN_W = 12;
    localparam int VLAN_HI_LSB = 16;
    localparam logic [31:0] DIST_RST = 32'h0000_0000;
    localparam logic [31:0] GRP_RST = 32'h0000_0000;
    localparam logic [31:0] KEY_RST = 32'h0000_0000;
    localparam logic [31:0] VLAN_RST = 32'h0001_0001;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        NONIP_SRC_MAC = 2'h0,
        NONIP_DST_MAC = 2'h1,
        NONIP_BOTH_MAC = 2'h2
    } tgd_nonip_t;
    typedef enum logic [2:0] {
        IP_SRC_MAC = 3'h0,
        IP_DST_MAC = 3'h1,
        IP_BOTH_MAC = 3'h2,
        IP_SOURCE_IP_HASH = 3'h3,
        IP_DESTINATION_IP_HASH = 3'h4,
        IP_BOTH_IP_HASH = 3'h5
    } tgd_ip_t;
endpackage : tgd_pkg
`default_nettype wire

`timescale 1ns/1ps
`default_nettype none
module trunk_group_distributor #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] portLinkUp,
    input wire logic [3:0] portGigSpeed,
    input wire logic [3:0] portFullDuplex,
    input wire logic [3:0] portStpForward,
    input wire logic frmValid,
    output logic frmReady,
    input wire logic frmIsIp,
    input wire logic [47:0] frmSrcMac,
    input wire logic [47:0] frmDstMac,
    input wire logic [31:0] frmSrcIp,
    input wire logic [31:0] frmDstIp,
    input wire logic [1:0] frmPort,
    output logic egrValid,
    input wire logic egrReady,
    output logic [1:0] egrPort,
    output logic egrDrop,
    output logic [47:0] portVlan,
    output logic [3:0] portForward
);
    localparam int DW = 1 + 48 + 48 + 32 + 32 + 2;

    if (FIFO_DEPTH != 32) begin : gBadDepth
        $error("descriptor buffer depth must be 32");
    end

    logic [31:0] distReg_ff;
    logic [31:0] grpReg_ff [tgd_pkg::NGROUP];
    logic [31:0] keyReg_ff;
    logic [31:0] vlanReg_ff [2];
    logic awHeld_ff;
    logic wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic doWrite;
    logic wrHit;
    logic [31:0] rdMux;
    logic rdHit;

    // register bus
    assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !wHeld_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    assign wrHit = (awAddr_ff == tgd_pkg::OFS_DIST) || (awAddr_ff == tgd_pkg::OFS_GRP0)
                || (awAddr_ff == tgd_pkg::OFS_GRP1) || (awAddr_ff == tgd_pkg::OFS_KEY)
                || (awAddr_ff == tgd_pkg::OFS_VLAN01) || (awAddr_ff == tgd_pkg::OFS_VLAN23);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            distReg_ff <= tgd_pkg::DIST_RST;
            grpReg_ff[0] <= tgd_pkg::GRP_RST;
            grpReg_ff[1] <= tgd_pkg::GRP_RST;
            keyReg_ff <= tgd_pkg::KEY_RST;
            vlanReg_ff[0] <= tgd_pkg::VLAN_RST;
            vlanReg_ff[1] <= tgd_pkg::VLAN_RST;
        end else if (doWrite) begin
            unique case (awAddr_ff)
                tgd_pkg::OFS_DIST: distReg_ff <= apply_strb(distReg_ff, wData_ff, wStrb_ff) & 32'h0000_001f;
                tgd_pkg::OFS_GRP0: grpReg_ff[0] <= apply_strb(grpReg_ff[0], wData_ff, wStrb_ff) & 32'h0000_003f;
                tgd_pkg::OFS_GRP1: grpReg_ff[1] <= apply_strb(grpReg_ff[1], wData_ff, wStrb_ff) & 32'h0000_003f;
                tgd_pkg::OFS_KEY: keyReg_ff <= apply_strb(keyReg_ff, wData_ff, wStrb_ff);
                tgd_pkg::OFS_VLAN01: vlanReg_ff[0] <= apply_strb(vlanReg_ff[0], wData_ff, wStrb_ff) & 32'h0fff_0fff;
                tgd_pkg::OFS_VLAN23: vlanReg_ff[1] <= apply_strb(vlanReg_ff[1], wData_ff, wStrb_ff) & 32'h0fff_0fff;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tgd_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? tgd_pkg::RESP_OKAY : tgd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // group validation
    logic [3:0] grpMem [tgd_pkg::NGROUP];
    logic [1:0] grpValid;
    logic [1:0] grpError;
    logic [1:0] grpLeader [tgd_pkg::NGROUP];
    logic [3:0] grpActive [tgd_pkg::NGROUP];
    logic [2:0] grpCnt [tgd_pkg::NGROUP];
    logic [2:0] grpActCnt [tgd_pkg::NGROUP];

    always_comb begin
        for (int g = 0; g < tgd_pkg::NGROUP; g++) begin
            logic en;
            logic dyn;
            logic overlap;
            logic speedOk;
            logic keyOk;
            logic [7:0] leadKey;
            en = grpReg_ff[g][tgd_pkg::GRP_EN_BIT];
            dyn = grpReg_ff[g][tgd_pkg::GRP_DYN_BIT];
            overlap = 1'b0;
            speedOk = 1'b0;
            keyOk = 1'b1;
            leadKey = 8'h00;
            grpMem[g] = grpReg_ff[g][tgd_pkg::GRP_MEM_LSB +: 4];
            grpCnt[g] = 3'h0;
            grpLeader[g] = 2'h0;
            for (int p = tgd_pkg::NPORT - 1; p >= 0; p--) begin
                if (grpMem[g][p]) begin
                    grpLeader[g] = 2'(p);
                end
            end
            for (int p = 0; p < tgd_pkg::NPORT; p++) begin
                grpCnt[g] = grpCnt[g] + {2'b00, grpMem[g][p]};
            end
            leadKey = keyReg_ff[grpLeader[g]*8 +: 8];
            for (int p = 0; p < tgd_pkg::NPORT; p++) begin
                if (grpMem[g][p] && dyn && keyReg_ff[p*8 +: 8] != leadKey) begin
                    keyOk = 1'b0;
                end
            end
            // the lower group keeps an overlapped port; the higher one is refused
            overlap = (g == 1) && grpReg_ff[0][tgd_pkg::GRP_EN_BIT]
                   && ((grpMem[g] & grpReg_ff[0][3:0]) != 4'h0);
            speedOk = (((grpMem[g] & portGigSpeed) == grpMem[g]) || ((grpMem[g] & portGigSpeed) == 4'h0))
                   && ((grpMem[g] & portFullDuplex) == grpMem[g]);
            grpValid[g] = en && (grpCnt[g] >= 3'd2) && !overlap && speedOk && keyOk;
            grpError[g] = en && !grpValid[g];
            // leader blocked by spanning tree blocks the whole group
            grpActive[g] = (grpValid[g] && portStpForward[grpLeader[g]])
                         ? (grpMem[g] & portLinkUp) : 4'h0;
            grpActCnt[g] = 3'h0;
            for (int p = 0; p < tgd_pkg::NPORT; p++) begin
                grpActCnt[g] = grpActCnt[g] + {2'b00, grpActive[g][p]};
            end
        end
    end

    // leader settings fan out
    logic [11:0] ownVlan [tgd_pkg::NPORT];
    always_comb begin
        ownVlan[0] = vlanReg_ff[0][0 +: tgd_pkg::VLAN_W];
        ownVlan[1] = vlanReg_ff[0][tgd_pkg::VLAN_HI_LSB +: tgd_pkg::VLAN_W];
        ownVlan[2] = vlanReg_ff[1][0 +: tgd_pkg::VLAN_W];
        ownVlan[3] = vlanReg_ff[1][tgd_pkg::VLAN_HI_LSB +: tgd_pkg::VLAN_W];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            portVlan <= 48'h0;
            portForward <= 4'h0;
        end else begin
            for (int p = 0; p < tgd_pkg::NPORT; p++) begin
                portVlan[p*12 +: 12] <= ownVlan[p];
                portForward[p] <= portStpForward[p];
                for (int g = tgd_pkg::NGROUP - 1; g >= 0; g--) begin
                    if (grpValid[g] && grpMem[g][p]) begin
                        portVlan[p*12 +: 12] <= ownVlan[grpLeader[g]];
                        portForward[p] <= portStpForward[grpLeader[g]];
                    end
                end
            end
        end
    end

    // read path
    always_comb begin
        rdHit = 1'b1;
        unique case (s_axi_araddr)
            tgd_pkg::OFS_DIST: rdMux = distReg_ff;
            tgd_pkg::OFS_GRP0: rdMux = grpReg_ff[0] | (32'h1 << tgd_pkg::GRP_NUM_LSB);
            tgd_pkg::OFS_GRP1: rdMux = grpReg_ff[1] | (32'h2 << tgd_pkg::GRP_NUM_LSB);
            tgd_pkg::OFS_KEY: rdMux = keyReg_ff;
            tgd_pkg::OFS_VLAN01: rdMux = vlanReg_ff[0];
            tgd_pkg::OFS_VLAN23: rdMux = vlanReg_ff[1];
            tgd_pkg::OFS_STATUS: rdMux = {20'h0, grpError, grpValid, grpActive[1], grpActive[0]};
            default: begin
                rdMux = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tgd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdHit ? tgd_pkg::RESP_OKAY : tgd_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // frame path
    logic [DW-1:0] fifoIn;
    logic [DW-1:0] fifoOut;
    logic fifoValid;
    logic fifoPop;

    assign fifoIn = {frmIsIp, frmSrcMac, frmDstMac, frmSrcIp, frmDstIp, frmPort};

    tgd_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH)
    ) uDescFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(frmValid),
        .inReady(frmReady),
        .inData(fifoIn),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    function automatic logic [7:0] fold48(input logic [47:0] v);
        return v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
    endfunction : fold48

    logic dIsIp;
    logic [47:0] dSrcMac;
    logic [47:0] dDstMac;
    logic [31:0] dSrcIp;
    logic [31:0] dDstIp;
    logic [1:0] dPort;
    logic [7:0] hashVal;
    logic [1:0] pickPort;
    logic pickDrop;

    assign {dIsIp, dSrcMac, dDstMac, dSrcIp, dDstIp, dPort} = fifoOut;
    // output stage stalls the buffer, so a full buffer drops frmReady
    assign fifoPop = !egrValid || egrReady;

    always_comb begin
        logic [7:0] sm;
        logic [7:0] dm;
        logic [7:0] si;
        logic [7:0] di;
        logic [1:0] nth;
        logic [1:0] seen;
        sm = fold48(dSrcMac);
        dm = fold48(dDstMac);
        si = fold48({16'h0000, dSrcIp});
        di = fold48({16'h0000, dDstIp});
        nth = 2'h0;
        seen = 2'h0;
        if (dIsIp) begin
            unique case (distReg_ff[tgd_pkg::DIST_IP_LSB +: 3])
                3'(tgd_pkg::IP_DST_MAC): hashVal = dm;
                3'(tgd_pkg::IP_BOTH_MAC): hashVal = sm ^ dm;
                3'(tgd_pkg::IP_SOURCE_IP_HASH): hashVal = si;
                3'(tgd_pkg::IP_DESTINATION_IP_HASH): hashVal = di;
                3'(tgd_pkg::IP_BOTH_IP_HASH): hashVal = si ^ di;
                default: hashVal = sm;
            endcase
        end else begin
            unique case (distReg_ff[tgd_pkg::DIST_NONIP_LSB +: 2])
                2'(tgd_pkg::NONIP_DST_MAC): hashVal = dm;
                2'(tgd_pkg::NONIP_BOTH_MAC): hashVal = sm ^ dm;
                default: hashVal = sm;
            endcase
        end
        pickPort = dPort;
        pickDrop = 1'b0;
        for (int g = tgd_pkg::NGROUP - 1; g >= 0; g--) begin
            if (grpValid[g] && grpMem[g][dPort]) begin
                pickDrop = (grpActCnt[g] == 3'h0);
                // flows stay put while the active set is unchanged
                nth = pickDrop ? 2'h0 : 2'(hashVal % {5'h00, grpActCnt[g]});
                seen = 2'h0;
                for (int p = 0; p < tgd_pkg::NPORT; p++) begin
                    if (grpActive[g][p]) begin
                        if (seen == nth) begin
                            pickPort = 2'(p);
                        end
                        seen = seen + 2'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            egrValid <= 1'b0;
            egrPort <= 2'h0;
            egrDrop <= 1'b0;
        end else if (fifoPop) begin
            egrValid <= fifoValid;
            if (fifoValid) begin
                egrPort <= pickPort;
                egrDrop <= pickDrop;
            end
        end
    end
endmodule : trunk_group_distributor
`default_nettype wire

// [trunk_group_distributor_tb.sv]
/* trunk_group_distributor_tb: scenario tasks over the register bus and frame path.
   assumes tgd_peer as far side and tgd_props bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module trunk_group_distributor_tb;
    logic clk = 1'h0, sys_rst = 1'h1, frmValid = 1'h0, frmIsIp = 1'h0, stall = 1'h0, peerCfg = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, frmReady, egrValid, egrReady, egrDrop;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, frmSrcIp = 32'h0a00_0006, frmDstIp = 32'h0a00_0009;
    logic [3:0] s_axi_wstrb = 4'hf, portGigSpeed = 4'hf, portFullDuplex = 4'hf, portStpForward = 4'hf, cut = 4'h0;
    logic [3:0] portLinkUp, portForward;
    logic [1:0] s_axi_bresp, s_axi_rresp, egrPort, frmPort = 2'h0;
    logic [47:0] frmSrcMac = 48'h00a0_0000_0005, frmDstMac = 48'h0000_0000_0102, portVlan;
    int errors = 0, numChecks = 0;
    always #5 clk = ~clk;
    trunk_group_distributor #(.FIFO_DEPTH(32)) uut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .portLinkUp, .portGigSpeed, .portFullDuplex, .portStpForward, .frmValid, .frmReady, .frmIsIp, .frmSrcMac,
        .frmDstMac, .frmSrcIp, .frmDstIp, .frmPort, .egrValid, .egrReady, .egrPort, .egrDrop, .portVlan, .portForward);
    tgd_peer peer (.stall, .peerCfg, .cut, .egrReady, .linkUp(portLinkUp));
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", s_axi_bresp, tgd_pkg::RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] r = tgd_pkg::RESP_OKAY);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rdata", s_axi_rdata & m, e);
        chk("rresp", s_axi_rresp, r);
    endtask : rd
    function automatic logic [7:0] fold(input logic [47:0] v);
        return v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
    endfunction : fold
    // hash key per distribution setting, both kinds share the low codes
    function automatic logic [7:0] key(input int md);
        case (md)
            1: return fold(frmDstMac);
            2: return fold(frmSrcMac) ^ fold(frmDstMac);
            3: return fold({16'h0, frmSrcIp});
            4: return fold({16'h0, frmDstIp});
            5: return fold({16'h0, frmSrcIp ^ frmDstIp});
            default: return fold(frmSrcMac);
        endcase
    endfunction : key
    function automatic logic [1:0] pick(input logic [3:0] m, input logic [7:0] k);
        int n = k % $countones(m);
        for (int i = 0; i < 4; i++) begin
            if (m[i] && n == 0) return 2'(i);
            if (m[i]) n--;
        end
        return 2'h0;
    endfunction : pick
    task automatic frm(input logic ip, input logic [1:0] p, input logic [1:0] ep, input logic ed);
        @(posedge clk);
        frmValid <= 1'h1;
        frmIsIp <= ip;
        frmPort <= p;
        do @(posedge clk); while (!frmReady);
        frmValid <= 1'h0;
        do @(posedge clk); while (!(egrValid && egrReady));
        chk("egrDrop", egrDrop, ed);
        if (!ed) chk("egrPort", egrPort, ep);
    endtask : frm
    task automatic t_regs;
        rd(tgd_pkg::OFS_DIST, 32'h1f, tgd_pkg::DIST_RST);
        rd(tgd_pkg::OFS_VLAN01, 32'hffff_ffff, tgd_pkg::VLAN_RST);
        rd(tgd_pkg::OFS_GRP1, 32'h0000_033f, 32'h0000_0200);
        rd(8'h1c, 32'hffff_ffff, 32'h0, tgd_pkg::RESP_SLVERR);
    endtask : t_regs
    task automatic t_hash;
        frm(1'h0, 2'h1, 2'h1, 1'h0);
        wr(tgd_pkg::OFS_GRP0, 32'h15);
        for (int md = 0; md < 6; md++) begin
            wr(tgd_pkg::OFS_DIST, 32'(md) << 2);
            frm(1'h1, 2'h0, pick(4'h5, key(md)), 1'h0);
        end
        for (int md = 0; md < 3; md++) begin
            wr(tgd_pkg::OFS_DIST, 32'(md));
            frm(1'h0, 2'h0, pick(4'h5, key(md)), 1'h0);
        end
        wr(tgd_pkg::OFS_GRP0, 32'h1b);
        frm(1'h0, 2'h0, pick(4'hb, key(2)), 1'h0);
    endtask : t_hash
    task automatic t_fail;
        wr(tgd_pkg::OFS_GRP0, 32'h15);
        wr(tgd_pkg::OFS_DIST, 32'h0);
        frm(1'h0, 2'h0, 2'h2, 1'h0);
        cut <= 4'h4;
        frm(1'h0, 2'h0, 2'h0, 1'h0);
        cut <= 4'h5;
        frm(1'h0, 2'h0, 2'h0, 1'h1);
        cut <= 4'h0;
    endtask : t_fail
    task automatic t_cfg;
        portGigSpeed <= 4'h1;
        frm(1'h0, 2'h0, 2'h0, 1'h0);
        rd(tgd_pkg::OFS_STATUS, 32'h500, 32'h400);
        portGigSpeed <= 4'hf;
        wr(tgd_pkg::OFS_GRP1, 32'h1c);
        rd(tgd_pkg::OFS_STATUS, 32'hf00, 32'h900);
        wr(tgd_pkg::OFS_KEY, 32'h2200_1100);
        wr(tgd_pkg::OFS_GRP1, 32'h3a);
        rd(tgd_pkg::OFS_STATUS, 32'hf00, 32'h900);
        wr(tgd_pkg::OFS_KEY, 32'h1100_1100);
        rd(tgd_pkg::OFS_STATUS, 32'hf00, 32'h300);
        portStpForward <= 4'hd;
        wr(tgd_pkg::OFS_VLAN01, 32'h0001_0005);
        repeat (2) @(posedge clk);
        chk("portForward", portForward, 4'h5);
        chk("portVlan", portVlan[35:24], 12'h005);
        frm(1'h0, 2'h1, 2'h1, 1'h1);
        portStpForward <= 4'hf;
    endtask : t_cfg
    // stalled peer fills the buffer, then it drains in full
    task automatic t_fifo;
        int n = 0, m = 0;
        stall <= 1'h1;
        @(posedge clk);
        frmValid <= 1'h1;
        do begin
            @(posedge clk);
            if (frmReady) n++;
        end while (frmReady && n < 40);
        frmValid <= 1'h0;
        chk("filled", n, 32'h21);
        stall <= 1'h0;
        for (int i = 0; i < 200 && m < n; i++) begin
            @(posedge clk);
            if (egrValid && egrReady) m++;
        end
        chk("drained", m, n);
    endtask : t_fifo
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        peerCfg <= 1'h1;
        t_regs();
        t_hash();
        t_fail();
        t_cfg();
        t_fifo();
        report_and_stop();
    end
    // whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule : trunk_group_distributor_tb
`default_nettype wire
